// file: inc/cgc_pkg.sv
package cgc_pkg;
    // register byte offsets on the bus
    localparam logic [7:0] CGC_OFF_CTRL1   = 8'h00;
    localparam logic [7:0] CGC_OFF_CTRL2   = 8'h04;
    localparam logic [7:0] CGC_OFF_STAT1   = 8'h08;
    localparam logic [7:0] CGC_OFF_STAT2   = 8'h0c;
    localparam logic [7:0] CGC_OFF_FILTER  = 8'h10;
    localparam logic [7:0] CGC_OFF_TRIM    = 8'h14;
    // control one fields
    localparam int CGC_C1_GAIN  = 7;
    localparam int CGC_C1_RANGE = 6;
    localparam int CGC_C1_REFERENCE_SELECT  = 5;
    localparam int CGC_C1_MODE_HI = 4;
    localparam int CGC_C1_MODE_LO = 3;
    localparam logic [7:0] CGC_C1_WMASK = 8'hfe;
    // control two fields
    localparam int CGC_C2_MUL_HI = 6;
    localparam int CGC_C2_MUL_LO = 4;
    localparam int CGC_C2_DIV_HI = 2;
    // status fields
    localparam int CGC_S1_IRQ    = 0;
    localparam int CGC_S1_LOCK   = 3;
    localparam int CGC_S1_ERCS   = 1;
    localparam int CGC_S1_MODE_LO = 6;
    localparam int CGC_S2_DCO_STABLE   = 1;
    localparam logic [15:0] CGC_FILT_MASK = 16'h0fff;
    // reset values
    localparam logic [7:0]  CGC_C1_RESET   = 8'h00;
    localparam logic [7:0]  CGC_C2_RESET   = 8'h00;
    localparam logic [11:0] CGC_FILT_RESET = 12'h000;
    localparam logic [7:0]  CGC_TRIM_RESET = 8'h80;
    // mode settle time before actual mode follows a request
    localparam int CGC_SETTLE_CYCLES = 8;
    localparam logic [3:0] CGC_SETTLE_MAX = 4'(CGC_SETTLE_CYCLES - 1);
    localparam logic [8:0] CGC_PNR_MIN = 9'h004;
    localparam logic [7:0] CGC_P_LOW = 8'h40;
    localparam logic [7:0] CGC_P_HIGH = 8'h01;
    localparam logic [1:0] CGC_AXI_OKAY   = 2'b00;
    localparam logic [1:0] CGC_AXI_SLVERR = 2'b10;
    typedef enum logic [1:0] {
        CGC_SELF_CLOCKED  = 2'b00,
        CGC_ENGAGED_INT   = 2'b01,
        CGC_BYPASSED_EXT  = 2'b10,
        CGC_ENGAGED_EXT   = 2'b11
    } cgc_mode_e;
    // fixed clock source select
    typedef enum logic [1:0] {
        CGC_FX_OFF = 2'b00,
        CGC_FX_BUS = 2'b01,
        CGC_FX_EXT = 2'b11
    } cgc_fx_e;
endpackage : cgc_pkg

// file: core/cgc_top.sv
// Operation
// [RULE_01] fixed clock equals bus clock in bypassed-external, and in engaged-external when RULE_02 does not hold
// [RULE_02] engaged-external: ext/2 when PN/R>=4 and locked
// [RULE_03] fixed clock off in engaged-internal or self-clocked
// [RULE_04] peripherals avoid fixed clock when it is off
// [RULE_05] gain bit selects high-gain oscillator with reference
// [RULE_06] gain bit accepts first write only after reset
// [RULE_07] reset starts in self-clocked scheme
// [RULE_08] self-clocked and bypassed: source divided by R
// [RULE_09] engaged internal: ref/7*64*N/R
// [RULE_10] engaged external: ext*P*N/R, P by range
// [RULE_11] multiplier code decodes to 4..18 step 2
// [RULE_12] divider code decodes to powers of two
// [RULE_13] control one field layout, bit 0 zero
// [RULE_14] mode 11 engaged external, 01 engaged internal
// [RULE_15] control two field layout with enables
// [RULE_16] status one read-only except flag clear
// [RULE_17] software polls dco stable before critical work
// [RULE_18] filter word 12 bits, top nibble reads zero
// [RULE_19] trim written only for internal tuning
// [RULE_20] software keeps N and R small
// [RULE_21] actual mode follows request after settle delay
// [RULE_22] fixed clock switches without truncated pulses
`timescale 1ns/1ps
`default_nettype none
module cgc_top
    import cgc_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input  wire logic              i_mclk,
    input  wire logic              i_reset_n,
    input  wire logic [ADDR_W-1:0] i_s_axi_awaddr,
    input  wire logic              i_s_axi_awvalid,
    output logic                   o_s_axi_awready,
    input  wire logic [31:0]       i_s_axi_wdata,
    input  wire logic [3:0]        i_s_axi_wstrb,
    input  wire logic              i_s_axi_wvalid,
    output logic                   o_s_axi_wready,
    output logic [1:0]             o_s_axi_bresp,
    output logic                   o_s_axi_bvalid,
    input  wire logic              i_s_axi_bready,
    input  wire logic [ADDR_W-1:0] i_s_axi_araddr,
    input  wire logic              i_s_axi_arvalid,
    output logic                   o_s_axi_arready,
    output logic [31:0]            o_s_axi_rdata,
    output logic [1:0]             o_s_axi_rresp,
    output logic                   o_s_axi_rvalid,
    input  wire logic              i_s_axi_rready,
    input  wire logic              i_internal_bus_clk,
    input  wire logic              i_ext_reference_clk,
    input  wire logic              i_lock,
    input  wire logic              i_dco_stable,
    input  wire logic              i_ext_clock_ok,
    input  wire logic              i_loss_event,
    input  wire logic [11:0]       i_loop_filter_word,
    input  wire logic              i_loop_filter_upd,
    output logic                   o_fixed_freq_clk,
    output logic                   o_high_gain_osc,
    output logic [1:0]             o_mode_actual,
    output logic [7:0]             o_mult_factor,
    output logic [7:0]             o_div_factor,
    output logic [7:0]             o_prescale,
    output logic [7:0]             o_trim,
    output logic [11:0]            o_filter
);

    ////////////////
    // reset synchroniser
    logic rst_meta;
    logic rst_n;
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    ////////////////
    // registers
    logic [7:0]  ctrl1;
    logic [7:0]  ctrl2;
    logic [11:0] filter;
    logic [7:0]  trim;
    logic        gain_locked;
    logic        irq_flag;
    logic [1:0]  mode_act;
    logic [3:0]  settle_cnt;

    // write channel capture; address and data accepted in either order
    logic              aw_held;
    logic              w_held;
    logic [ADDR_W-1:0] aw_addr;
    logic [31:0]       w_data;
    logic [3:0]        w_strb;
    logic              do_write;
    logic              wr_ok;
    assign do_write = aw_held && w_held && !o_s_axi_bvalid;

    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            aw_held         <= 1'b0;
            w_held          <= 1'b0;
            aw_addr         <= '0;
            w_data          <= '0;
            w_strb          <= '0;
            o_s_axi_awready <= 1'b0;
            o_s_axi_wready  <= 1'b0;
        end else begin
            o_s_axi_awready <= !aw_held && !o_s_axi_awready && i_s_axi_awvalid;
            o_s_axi_wready  <= !w_held && !o_s_axi_wready && i_s_axi_wvalid;
            if (i_s_axi_awvalid && o_s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= i_s_axi_awaddr;
            end else if (do_write) begin
                aw_held <= 1'b0;
            end
            if (i_s_axi_wvalid && o_s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= i_s_axi_wdata;
                w_strb <= i_s_axi_wstrb;
            end else if (do_write) begin
                w_held <= 1'b0;
            end
        end
    end

    // write decode
    logic sel_c1;
    logic sel_c2;
    logic sel_s1;
    logic sel_filt;
    logic sel_trim;
    always_comb begin
        sel_c1   = 1'b0;
        sel_c2   = 1'b0;
        sel_s1   = 1'b0;
        sel_filt = 1'b0;
        sel_trim = 1'b0;
        wr_ok    = 1'b1;
        if (aw_addr[7:0] == CGC_OFF_CTRL1) begin
            sel_c1 = 1'b1;
        end else if (aw_addr[7:0] == CGC_OFF_CTRL2) begin
            sel_c2 = 1'b1;
        end else if (aw_addr[7:0] == CGC_OFF_STAT1) begin
            sel_s1 = 1'b1;
        end else if (aw_addr[7:0] == CGC_OFF_STAT2) begin
            sel_s1 = 1'b0;
        end else if (aw_addr[7:0] == CGC_OFF_FILTER) begin
            sel_filt = 1'b1;
        end else if (aw_addr[7:0] == CGC_OFF_TRIM) begin
            sel_trim = 1'b1;
        end else begin
            wr_ok = 1'b0;
        end
    end

    // write response
    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            o_s_axi_bvalid <= 1'b0;
            o_s_axi_bresp  <= CGC_AXI_OKAY;
        end else if (do_write) begin
            o_s_axi_bvalid <= 1'b1;
            o_s_axi_bresp  <= wr_ok ? CGC_AXI_OKAY : CGC_AXI_SLVERR;
        end else if (i_s_axi_bready) begin
            o_s_axi_bvalid <= 1'b0;
        end
    end

    // control one; the gain bit freezes after its first write
    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl1       <= CGC_C1_RESET; // RULE_07
            gain_locked <= 1'b0;
        end else if (do_write && sel_c1 && w_strb[0]) begin
            ctrl1[7:1]  <= w_data[7:1] & CGC_C1_WMASK[7:1]; // RULE_13
            if (gain_locked) begin
                ctrl1[CGC_C1_GAIN] <= ctrl1[CGC_C1_GAIN]; // RULE_06
            end
            gain_locked <= 1'b1; // RULE_06
        end
    end

    // control two, trim, filter
    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl2 <= CGC_C2_RESET;
        end else if (do_write && sel_c2 && w_strb[0]) begin
            ctrl2 <= w_data[7:0]; // RULE_15
        end
    end

    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            trim <= CGC_TRIM_RESET;
        end else if (do_write && sel_trim && w_strb[0]) begin
            trim <= w_data[7:0];
        end
    end

    // loop update wins over software
    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            filter <= CGC_FILT_RESET;
        end else if (i_loop_filter_upd) begin
            filter <= i_loop_filter_word; // RULE_18
        end else if (do_write && sel_filt) begin
            if (w_strb[0]) begin
                filter[7:0] <= w_data[7:0];
            end
            if (w_strb[1]) begin
                filter[11:8] <= w_data[11:8];
            end
        end
    end

    // interrupt flag: loss event sets, write of one clears, set wins
    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            irq_flag <= 1'b0;
        end else if (i_loss_event) begin
            irq_flag <= 1'b1;
        end else if (do_write && sel_s1 && w_strb[0] && w_data[CGC_S1_IRQ]) begin
            irq_flag <= 1'b0; // RULE_16
        end
    end

    ////////////////
    // actual mode follows the request after a settle delay
    logic [1:0] mode_req;
    assign mode_req = ctrl1[CGC_C1_MODE_HI:CGC_C1_MODE_LO];
    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            mode_act   <= CGC_SELF_CLOCKED; // RULE_07
            settle_cnt <= '0;
        end else if (mode_act == mode_req) begin
            settle_cnt <= '0;
        end else if (settle_cnt == CGC_SETTLE_MAX) begin
            settle_cnt <= '0;
            mode_act   <= mode_req; // RULE_21 RULE_14
        end else begin
            settle_cnt <= settle_cnt + 4'h1;
        end
    end

    ////////////////
    // factor decodes
    logic [7:0] mult_n;
    logic [7:0] div_r;
    logic [7:0] pre_p;
    logic [2:0] mul_code;
    logic [2:0] div_code;
    assign mul_code = ctrl2[CGC_C2_MUL_HI:CGC_C2_MUL_LO];
    assign div_code = ctrl2[CGC_C2_DIV_HI:0];
    assign mult_n = 8'h04 + {4'h0, mul_code, 1'b0}; // RULE_11
    assign div_r  = 8'h01 << div_code; // RULE_12
    assign pre_p  = ctrl1[CGC_C1_RANGE] ? CGC_P_HIGH : CGC_P_LOW; // RULE_10

    // (P*N)/R >= 4, compared as P*N >= 4*R to avoid a divider
    logic [15:0] pn;
    logic [15:0] four_r;
    logic        ratio_ok;
    assign pn       = pre_p * mult_n;
    assign four_r   = {6'h00, div_r, 2'b00};
    assign ratio_ok = pn >= four_r; // RULE_02

    // registered factors for the frequency path
    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            o_mult_factor <= 8'h04;
            o_div_factor  <= 8'h01;
            o_prescale    <= CGC_P_LOW;
            o_trim        <= CGC_TRIM_RESET;
            o_filter      <= CGC_FILT_RESET;
            o_mode_actual <= CGC_SELF_CLOCKED;
            o_high_gain_osc <= 1'b0;
        end else begin
            o_mult_factor <= mult_n; // RULE_09 RULE_10
            o_div_factor  <= div_r; // RULE_08
            o_prescale    <= pre_p;
            o_trim        <= trim;
            o_filter      <= filter;
            o_mode_actual <= mode_act;
            o_high_gain_osc <= ctrl1[CGC_C1_GAIN] && ctrl1[CGC_C1_REFERENCE_SELECT]; // RULE_05
        end
    end

    ////////////////
    // fixed clock source choice
    cgc_fx_e fx_want;
    always_comb begin
        case (mode_act)
            CGC_ENGAGED_EXT:  fx_want = (ratio_ok && i_lock) ? CGC_FX_EXT : CGC_FX_BUS; // RULE_02
            CGC_BYPASSED_EXT: fx_want = CGC_FX_BUS; // RULE_01
            default:          fx_want = CGC_FX_OFF; // RULE_03
        endcase
    end

    // ext reference halved: toggle on each sampled rising edge
    logic ext_q;
    logic ext_half;
    logic bus_q;
    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            ext_q    <= 1'b0;
            ext_half <= 1'b0;
            bus_q    <= 1'b0;
        end else begin
            ext_q <= i_ext_reference_clk;
            bus_q <= i_internal_bus_clk;
            if (i_ext_reference_clk && !ext_q) begin
                ext_half <= !ext_half;
            end
        end
    end

    // glitch-free switch: source changes only while both are low
    cgc_fx_e fx_cur;
    logic    cur_level;
    logic    want_level;
    always_comb begin
        case (fx_cur)
            CGC_FX_EXT: cur_level = ext_half;
            CGC_FX_BUS: cur_level = bus_q;
            default:    cur_level = 1'b0;
        endcase
        case (fx_want)
            CGC_FX_EXT: want_level = ext_half;
            CGC_FX_BUS: want_level = bus_q;
            default:    want_level = 1'b0;
        endcase
    end

    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            fx_cur           <= CGC_FX_OFF;
            o_fixed_freq_clk <= 1'b0;
        end else begin
            if (fx_cur != fx_want && !cur_level && !want_level) begin
                fx_cur <= fx_want; // RULE_22
            end
            o_fixed_freq_clk <= cur_level; // RULE_01
        end
    end

    ////////////////
    // read channel
    logic [31:0] rd_mux;
    logic        rd_ok;
    always_comb begin
        rd_mux = 32'h0000_0000;
        rd_ok  = 1'b1;
        if (i_s_axi_araddr[7:0] == CGC_OFF_CTRL1) begin
            rd_mux[7:0] = ctrl1 & CGC_C1_WMASK; // RULE_13
        end else if (i_s_axi_araddr[7:0] == CGC_OFF_CTRL2) begin
            rd_mux[7:0] = ctrl2;
        end else if (i_s_axi_araddr[7:0] == CGC_OFF_STAT1) begin
            rd_mux[CGC_S1_MODE_LO+1:CGC_S1_MODE_LO] = mode_act;
            rd_mux[CGC_S1_LOCK] = i_lock;
            rd_mux[CGC_S1_ERCS] = i_ext_clock_ok;
            rd_mux[CGC_S1_IRQ]  = irq_flag;
        end else if (i_s_axi_araddr[7:0] == CGC_OFF_STAT2) begin
            rd_mux[CGC_S2_DCO_STABLE] = i_dco_stable;
        end else if (i_s_axi_araddr[7:0] == CGC_OFF_FILTER) begin
            rd_mux[15:0] = {4'h0, filter} & CGC_FILT_MASK; // RULE_18
        end else if (i_s_axi_araddr[7:0] == CGC_OFF_TRIM) begin
            rd_mux[7:0] = trim;
        end else begin
            rd_ok = 1'b0;
        end
    end

    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            o_s_axi_arready <= 1'b0;
            o_s_axi_rvalid  <= 1'b0;
            o_s_axi_rdata   <= '0;
            o_s_axi_rresp   <= CGC_AXI_OKAY;
        end else begin
            o_s_axi_arready <= !o_s_axi_arready && !o_s_axi_rvalid && i_s_axi_arvalid;
            if (i_s_axi_arvalid && o_s_axi_arready) begin
                o_s_axi_rvalid <= 1'b1;
                o_s_axi_rdata  <= rd_mux;
                o_s_axi_rresp  <= rd_ok ? CGC_AXI_OKAY : CGC_AXI_SLVERR;
            end else if (i_s_axi_rready) begin
                o_s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule : cgc_top
`default_nettype wire

// file: testbench/cgc_top_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module cgc_top_checker
    import cgc_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic              i_mclk,
    input wire logic              i_reset_n,
    input wire logic [ADDR_W-1:0] i_s_axi_awaddr,
    input wire logic              i_s_axi_awvalid,
    input wire logic              o_s_axi_awready,
    input wire logic              i_s_axi_wvalid,
    input wire logic              o_s_axi_wready,
    input wire logic [1:0]        o_s_axi_bresp,
    input wire logic              o_s_axi_bvalid,
    input wire logic              i_s_axi_bready,
    input wire logic              i_s_axi_arvalid,
    input wire logic              o_s_axi_arready,
    input wire logic [31:0]       o_s_axi_rdata,
    input wire logic              o_s_axi_rvalid,
    input wire logic              i_s_axi_rready,
    input wire logic              o_fixed_freq_clk,
    input wire logic [1:0]        o_mode_actual,
    input wire logic [7:0]        o_mult_factor,
    input wire logic [7:0]        o_div_factor,
    input wire logic [7:0]        o_prescale
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_reset_n);

    ////////////////
    // handshakes; aw and w offered together
    sequence s_wr_taken;
        i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid && o_s_axi_wready;
    endsequence
    sequence s_rd_taken;
        i_s_axi_arvalid && o_s_axi_arready;
    endsequence
    // schemes with the fixed clock off
    sequence s_fx_off;
        o_mode_actual inside {CGC_SELF_CLOCKED, CGC_ENGAGED_INT};
    endsequence

    ////////////////
    a_write_resp: assert property (s_wr_taken |-> ##[1:3] o_s_axi_bvalid)
        else $error("write response late");
    a_bresp_hold: assert property (o_s_axi_bvalid && !i_s_axi_bready
        |=> o_s_axi_bvalid && $stable(o_s_axi_bresp)) else $error("write response dropped");
    a_read_resp: assert property (s_rd_taken |=> o_s_axi_rvalid)
        else $error("read data late");
    a_rdata_hold: assert property (o_s_axi_rvalid && !i_s_axi_rready
        |=> o_s_axi_rvalid && $stable(o_s_axi_rdata)) else $error("read data dropped");
    // switching waits for a low phase
    a_fixed_off: assert property (s_fx_off [*8] ##1 s_fx_off [*4] |-> !o_fixed_freq_clk)
        else $error("fixed clock running while off");
    a_mode_settle: assert property ((s_wr_taken ##0 i_s_axi_awaddr == ADDR_W'(CGC_OFF_CTRL1))
        |=> $stable(o_mode_actual) [*4]) else $error("mode followed request at once");
    a_mult_decode: assert property (o_mult_factor >= 8'd4 && o_mult_factor <= 8'd18
        && !o_mult_factor[0]) else $error("multiplier out of table");
    a_div_decode: assert property ($onehot(o_div_factor))
        else $error("divider not a power of two");
    a_prescale_val: assert property (o_prescale == CGC_P_LOW || o_prescale == CGC_P_HIGH)
        else $error("prescale not 64 or 1");
endmodule : cgc_top_checker

bind cgc_top cgc_top_checker #(.ADDR_W(ADDR_W)) u_chk (.*);
`default_nettype wire

// file: testbench/cgc_periph_model.sv
`timescale 1ns/1ps
`default_nettype none
module cgc_periph_model
    import cgc_pkg::*;
(
    input wire logic        i_mclk,
    input wire logic        i_reset_n,
    input wire logic        i_fixed_clk,
    input wire logic [1:0]  i_mode_actual,
    output logic [15:0]     o_raw_rises,
    output logic [15:0]     o_used_rises,
    output logic [15:0]     o_short_pulses
);
    logic       prev;
    logic [3:0] high_len;

    ////////////////
    // counts edges a fixed-clock peripheral sees
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            prev           <= 1'b0;
            high_len       <= 4'h0;
            o_raw_rises    <= '0;
            o_used_rises   <= '0;
            o_short_pulses <= '0;
        end else begin
            prev     <= i_fixed_clk;
            high_len <= !i_fixed_clk ? 4'h0 : (high_len == 4'hf ? high_len : high_len + 4'h1);
            if (i_fixed_clk && !prev) begin
                o_raw_rises <= o_raw_rises + 16'h1;
            end
            // no use of the fixed clock while it is off
            if (i_fixed_clk && !prev
                && !(i_mode_actual inside {CGC_SELF_CLOCKED, CGC_ENGAGED_INT})) begin
                o_used_rises <= o_used_rises + 16'h1;
            end
            // high phase shorter than any legal source
            if (!i_fixed_clk && prev && high_len < 4'h2) begin
                o_short_pulses <= o_short_pulses + 16'h1;
            end
        end
    end
endmodule : cgc_periph_model
`default_nettype wire

// file: testbench/tb_cgc_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_cgc_top
    import cgc_pkg::*;
;
    logic        clk = 1'b0, rst_n = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0, bus_clk = 1'b0, ext_clk = 1'b0, lock = 1'b0;
    logic        dco_stable = 1'b0, ext_ok = 1'b0, loss_ev = 1'b0, filt_upd = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rd, v, rd_w;
    logic [3:0]  wstrb = 4'h0, div_cnt = 4'h0;
    logic [11:0] filt_word = 12'h000, filt;
    logic        awready, wready, bvalid, arready, rvalid, fx_clk, osc_gain_select;
    logic [1:0]  bresp, rresp, rsp, mode_act;
    logic [7:0]  mult, div, presc, trim;
    logic [15:0] raw, used, shrt;
    int          n_fail = 0, tests_run = 0, k;

    always #5 clk = ~clk;
    // bus clk period 4, ext ref period 6
    always @(posedge clk) begin
        div_cnt <= (div_cnt == 4'd11) ? 4'd0 : div_cnt + 4'd1;
        bus_clk <= div_cnt[1];
        ext_clk <= (div_cnt % 6) >= 3;
    end

    cgc_top #(.ADDR_W(8)) dut_u (.i_mclk(clk), .i_reset_n(rst_n),
        .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready),
        .i_s_axi_wdata(wdata), .i_s_axi_wstrb(wstrb), .i_s_axi_wvalid(wvalid),
        .o_s_axi_wready(wready), .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid),
        .i_s_axi_bready(bready), .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid),
        .o_s_axi_arready(arready), .o_s_axi_rdata(rd_w), .o_s_axi_rresp(rresp),
        .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready), .i_internal_bus_clk(bus_clk),
        .i_ext_reference_clk(ext_clk), .i_lock(lock), .i_dco_stable(dco_stable),
        .i_ext_clock_ok(ext_ok), .i_loss_event(loss_ev), .i_loop_filter_word(filt_word),
        .i_loop_filter_upd(filt_upd), .o_fixed_freq_clk(fx_clk), .o_high_gain_osc(osc_gain_select),
        .o_mode_actual(mode_act), .o_mult_factor(mult), .o_div_factor(div),
        .o_prescale(presc), .o_trim(trim), .o_filter(filt));
    cgc_periph_model u_periph (.i_mclk(clk), .i_reset_n(rst_n), .i_fixed_clk(fx_clk),
        .i_mode_actual(mode_act), .o_raw_rises(raw), .o_used_rises(used),
        .o_short_pulses(shrt));

    ////////////////
    function automatic int f_rises(input logic ext_sel); // rises in a 48-cycle window
        return ext_sel ? 4 : 12;
    endfunction : f_rises
    function automatic logic f_ext(input int p, input int n, input int r, input logic lk);
        return lk && (p * n >= 4 * r);
    endfunction : f_ext
    function automatic logic [31:0] f_stat1(input logic [1:0] m, input logic lk, input logic ok,
                                            input logic irq);
        return {24'h0, m, 2'b00, lk, 1'b0, ok, irq};
    endfunction : f_stat1

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic aw_ok = 1'b0;
        logic w_ok = 1'b0;
        awaddr <= a; awvalid <= 1'b1; wdata <= d; wstrb <= 4'hf; wvalid <= 1'b1; bready <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge clk);
            if (!aw_ok && awready) begin aw_ok = 1'b1; awvalid <= 1'b0; end
            if (!w_ok && wready) begin w_ok = 1'b1; wvalid <= 1'b0; end
        end
        do @(posedge clk); while (!bvalid);
        rsp = bresp;
        bready <= 1'b0;
        @(posedge clk);
    endtask : wr
    task automatic rd_reg(input logic [7:0] a);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do @(posedge clk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge clk); while (!rvalid);
        rd = rd_w; rsp = rresp; rready <= 1'b0;
        @(posedge clk);
    endtask : rd_reg
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        rd_reg(a);
        check($sformatf("reg %h", a), rd, exp);
    endtask : rchk
    task automatic do_reset;
        rst_n <= 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
    endtask : do_reset
    // settle, then count fixed clock rises
    task automatic fx_win(input int exp, input logic off);
        logic [15:0] a0, u0, d;
        repeat (16) @(posedge clk);
        a0 = raw;
        u0 = used;
        repeat (48) @(posedge clk);
        d = off ? raw - a0 : used - u0;
        check("fixed rises", off ? d : 32'(d + 1 >= exp && d <= exp + 1), off ? 0 : 1);
    endtask : fx_win
    task automatic test_done;
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : test_done

    ////////////////
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        test_done;
    end
    initial begin
        void'($urandom(32'h5a5e9ea1));
        do_reset;
        check("mode", mode_act, CGC_SELF_CLOCKED);
        check("mult", mult, 4); check("div", div, 1); check("presc", presc, 64);
        rchk(CGC_OFF_CTRL1, 0);
        rchk(CGC_OFF_TRIM, 32'h80);
        fx_win(0, 1'b1);
        for (k = 0; k < 8; k++) begin
            v = (32'($urandom) & 32'h88) | 32'(k << 4) | 32'(7 - k);
            wr(CGC_OFF_CTRL2, v);
            check("mult", mult, 4 + 2 * k);
            check("div", div, 1 << (7 - k));
            rchk(CGC_OFF_CTRL2, v);
        end
        // gain bit: first write sticks
        wr(CGC_OFF_CTRL1, 32'ha1); check("gain", osc_gain_select, 1);
        rchk(CGC_OFF_CTRL1, 32'ha0);
        wr(CGC_OFF_CTRL1, 32'h20); rchk(CGC_OFF_CTRL1, 32'ha0);
        wr(CGC_OFF_CTRL1, 32'h80); check("gain", osc_gain_select, 0);
        wr(CGC_OFF_CTRL1, 32'h30); check("mode", mode_act, CGC_SELF_CLOCKED);
        fx_win(f_rises(1'b0), 1'b0); check("mode", mode_act, CGC_BYPASSED_EXT);
        wr(CGC_OFF_CTRL2, 0); lock <= 1'b1; ext_ok <= 1'b1;
        wr(CGC_OFF_CTRL1, 32'h38); fx_win(f_rises(f_ext(64, 4, 1, 1)), 1'b0);
        check("mode", mode_act, CGC_ENGAGED_EXT); check("presc", presc, 64);
        lock <= 1'b0; fx_win(f_rises(f_ext(64, 4, 1, 0)), 1'b0);
        lock <= 1'b1; wr(CGC_OFF_CTRL1, 32'h78); check("presc", presc, 1);
        fx_win(f_rises(f_ext(1, 4, 1, 1)), 1'b0);
        wr(CGC_OFF_CTRL2, 1); fx_win(f_rises(f_ext(1, 4, 2, 1)), 1'b0);
        wr(CGC_OFF_CTRL1, 32'h28); fx_win(0, 1'b1);
        check("mode", mode_act, CGC_ENGAGED_INT); check("short", shrt, 0);
        // loss event sets flag, software clears
        loss_ev <= 1'b1; @(posedge clk); loss_ev <= 1'b0; dco_stable <= 1'b1;
        rchk(CGC_OFF_STAT1, f_stat1(2'b01, 1'b1, 1'b1, 1'b1));
        wr(CGC_OFF_STAT1, 32'hff); rchk(CGC_OFF_STAT1, f_stat1(2'b01, 1'b1, 1'b1, 1'b0));
        rchk(CGC_OFF_STAT2, 32'h2);
        wr(CGC_OFF_FILTER, 32'hffff); rchk(CGC_OFF_FILTER, 32'h0fff);
        filt_word <= 12'($urandom); filt_upd <= 1'b1; @(posedge clk); filt_upd <= 1'b0;
        repeat (2) @(posedge clk); check("filter", filt, filt_word);
        v = 32'($urandom) & 32'hff; wr(CGC_OFF_TRIM, v); rchk(CGC_OFF_TRIM, v);
        check("trim", trim, v);
        // unmapped: error, zero data
        rd_reg(8'h20); check("rresp", rsp, CGC_AXI_SLVERR); check("rdata", rd, 0);
        wr(8'h24, 32'h5); check("bresp", rsp, CGC_AXI_SLVERR);
        // second reset reopens gain write
        do_reset; wr(CGC_OFF_CTRL1, 32'h20); wr(CGC_OFF_CTRL1, 32'ha0);
        rchk(CGC_OFF_CTRL1, 32'h20); check("gain", osc_gain_select, 0);
        test_done;
    end
endmodule : tb_cgc_top
`default_nettype wire
